// File: core/mow_pkg.sv
// Package for the mask override and walk base register bank.
// Assumes a single core clock domain and coprocessor-style register transfers.
package mow_pkg;
	// ------------------------------------------------------------
	// Register selection
	// ------------------------------------------------------------
	typedef enum logic [1:0] {MOW_SEL_NONE, MOW_SEL_OVR, MOW_SEL_TTB} mow_sel_t;

	// ------------------------------------------------------------
	// Field positions and widths
	// ------------------------------------------------------------
	localparam int MOW_AMO_BIT      = 8;
	localparam int MOW_IMO_BIT      = 7;
	localparam int MOW_FMO_BIT      = 6;
	localparam int MOW_INNER_WALK_ATTR_LO_BIT  = 6;
	localparam int MOW_RSVD_RAZ_BIT = 5;
	localparam int MOW_RGN_HI_BIT   = 4;
	localparam int MOW_RGN_LO_BIT   = 3;
	localparam int MOW_UNIMP_BIT    = 2;
	localparam int MOW_SHARE_BIT    = 1;
	localparam int MOW_INNER_WALK_ATTR_HI_BIT  = 0;
	localparam int MOW_ADDR_LO_BIT  = 7;
	localparam int MOW_ADDR_W       = 25;
	localparam int MOW_SPLIT_W      = 3;
	localparam int MOW_SPLIT_BASE   = 14;

	// ------------------------------------------------------------
	// Reset values and attribute encodings
	// ------------------------------------------------------------
	localparam logic [31:0] MOW_RESET_VALUE = 32'h0000_0000;
	localparam logic [1:0]  MOW_ATTR_NC     = 2'h0;
	localparam logic [1:0]  MOW_ATTR_WBWA   = 2'h1;
	localparam logic [1:0]  MOW_ATTR_WT     = 2'h2;
	localparam logic [1:0]  MOW_ATTR_WBNA   = 2'h3;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic in_secure;
		logic privileged;
		logic ext_abort_routing;
		logic irq_routing;
		logic fiq_routing;
	} mow_state_t;

	typedef struct packed {
		logic        async_abort_override;
		logic        irq_mask_override;
		logic        fiq_mask_override;
	} mow_ovr_t;

	typedef struct packed {
		logic [MOW_ADDR_W-1:0] table_addr;
		logic [1:0]            inner_walk_attr;
		logic [1:0]            outer_walk_attr;
		logic                  shared;
	} mow_ttb_t;

	typedef struct packed {
		logic [31:0] walk_base;
		logic        dcache_lookup;
		logic [1:0]  outer_walk_attr;
		logic        shared;
	} mow_walk_t;
endpackage

// File: core/mow_mask_gate.sv
// Mask override gate: turns the stored override bits into effective masks.
// Assumes the core supplies its status mask bits and security routing.
`timescale 1ns/1ns
module mow_mask_gate
(
	// Control
	input  wire mow_pkg::mow_state_t st_i,
	input  wire mow_pkg::mow_ovr_t   ovr_i,
	// Program status mask bits
	input  wire logic                abort_mask_i,
	input  wire logic                irq_mask_i,
	input  wire logic                fiq_mask_i,
	// Effective masks
	output logic                     abort_mask_eff_o,
	output logic                     irq_mask_eff_o,
	output logic                     fiq_mask_eff_o
);
	import mow_pkg::*;

	logic ns;

	always_comb
	begin
		ns = ~st_i.in_secure;
		abort_mask_eff_o = abort_mask_i & ~(ns & st_i.ext_abort_routing & ovr_i.async_abort_override);
		irq_mask_eff_o   = irq_mask_i & ~(ns & st_i.irq_routing & ovr_i.irq_mask_override);
		fiq_mask_eff_o   = fiq_mask_i & ~(ns & st_i.fiq_routing & ovr_i.fiq_mask_override);
	end
endmodule

// File: core/mow_walk_attr.sv
// Walk attribute decode: forms the level-one base and walk attributes.
// Assumes the split width comes from the translation control register.
`timescale 1ns/1ns
module mow_walk_attr
(
	// Stored table base
	input  wire mow_pkg::mow_ttb_t          ttb_i,
	input  wire logic [mow_pkg::MOW_SPLIT_W-1:0] split_i,
	// Walk view
	output mow_pkg::mow_walk_t              walk_o
);
	import mow_pkg::*;

	logic [31:0] full;
	logic [31:0] keep;

	always_comb
	begin
		full = {ttb_i.table_addr, {MOW_ADDR_LO_BIT{1'b0}}};
		// Only the top 32-(14-N) bits are used; alignment follows N
		keep = 32'hFFFF_FFFF << (MOW_SPLIT_BASE - int'(split_i));
		walk_o.walk_base = full & keep;
		walk_o.dcache_lookup = (ttb_i.inner_walk_attr == MOW_ATTR_WBWA)
			|| (ttb_i.inner_walk_attr == MOW_ATTR_WBNA);
		walk_o.outer_walk_attr = ttb_i.outer_walk_attr;
		walk_o.shared = ttb_i.shared;
	end
endmodule

// File: core/mow_top.sv
// Mask override control and banked walk table base zero register bank.
// Assumes coprocessor transfers arrive as one-cycle strobes in the core clock.
// Overview of operation
// - Override control reachable only from Secure privileged modes.
// - Non-secure, abort routing set: abort override unmasks asynchronous abort.
// - Abort override ignored in Secure state or with abort routing clear.
// - Non-secure, IRQ routing set: IRQ override bypasses IRQ mask.
// - IRQ override ignored in Secure state or IRQ routing clear.
// - Non-secure, FIQ routing set: FIQ override bypasses FIQ mask.
// - FIQ override ignored in Secure state or FIQ routing clear.
// - Table base zero banked Secure/Non-secure, privileged access only.
// - Secure privileged table base write undefined while write lock high.
// - Table pointer in bits 31 to 14-N, rest down to 7 reserved.
// - Inner attribute is bit 0 high, bit 6 low.
// - Walks look up data cache only for write-back inner attributes.
// - Outer attribute in bits 4:3 with the four cache encodings.
// - Bit 1 set walks shared memory, clear non-shared.
// - Bit 2 unimplemented, bit 5 reads zero, writes ignored.
// - Writes store table address from bits 31:7.
// - Only N-allowed address bits used, setting table alignment.
// - Reads return full stored address bits 31:7 regardless of N.
`timescale 1ns/1ns
module mow_top
(
	// Clock and reset
	input  wire logic                            clk_i,
	input  wire logic                            reset_n_i,
	// Core state
	input  wire mow_pkg::mow_state_t             st_i,
	input  wire logic                            secure_cfg_write_lock_i,
	input  wire logic [mow_pkg::MOW_SPLIT_W-1:0] split_i,
	// Register transfer
	input  wire logic                            req_i,
	input  wire logic                            wr_i,
	input  wire mow_pkg::mow_sel_t               sel_i,
	input  wire logic [31:0]                     wdata_i,
	output logic [31:0]                          rdata_o,
	output logic                                 rvalid_o,
	output logic                                 undef_o,
	// Program status mask bits
	input  wire logic                            abort_mask_i,
	input  wire logic                            irq_mask_i,
	input  wire logic                            fiq_mask_i,
	// Effective masks and walk view
	output logic                                 abort_mask_eff_o,
	output logic                                 irq_mask_eff_o,
	output logic                                 fiq_mask_eff_o,
	output mow_pkg::mow_walk_t                   walk_o
);
	import mow_pkg::*;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	mow_ovr_t    ovr;
	mow_ovr_t    next_ovr;
	mow_ttb_t    ttb_s;
	mow_ttb_t    next_ttb_s;
	mow_ttb_t    ttb_ns;
	mow_ttb_t    next_ttb_ns;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic        rvalid;
	logic        next_rvalid;
	logic        undef;
	logic        next_undef;
	mow_ttb_t    ttb_cur;

	// Pack a table base for readback; bits 5 and 2 stay zero
	function automatic logic [31:0] ttb_read(input mow_ttb_t t);
		logic [31:0] v;
		v = MOW_RESET_VALUE;
		v[31:MOW_ADDR_LO_BIT] = t.table_addr;
		v[MOW_INNER_WALK_ATTR_HI_BIT]    = t.inner_walk_attr[1];
		v[MOW_INNER_WALK_ATTR_LO_BIT]    = t.inner_walk_attr[0];
		v[MOW_RGN_HI_BIT:MOW_RGN_LO_BIT] = t.outer_walk_attr;
		v[MOW_SHARE_BIT]      = t.shared;
		return v;
	endfunction

	function automatic mow_ttb_t ttb_write(input logic [31:0] w);
		mow_ttb_t t;
		t.table_addr      = w[31:MOW_ADDR_LO_BIT];
		t.inner_walk_attr = {w[MOW_INNER_WALK_ATTR_HI_BIT], w[MOW_INNER_WALK_ATTR_LO_BIT]};
		t.outer_walk_attr = w[MOW_RGN_HI_BIT:MOW_RGN_LO_BIT];
		t.shared          = w[MOW_SHARE_BIT];
		return t;
	endfunction

	// ------------------------------------------------------------
	// Access control and register update
	// ------------------------------------------------------------
	always_comb
	begin
		next_ovr    = ovr;
		next_ttb_s  = ttb_s;
		next_ttb_ns = ttb_ns;
		next_rdata  = rdata;
		next_rvalid = 1'b0;
		next_undef  = 1'b0;
		if (req_i)
		begin
			if (sel_i == MOW_SEL_OVR)
			begin
				if (!(st_i.privileged && st_i.in_secure))
				begin
					next_undef = 1'b1;
				end
				else if (wr_i)
				begin
					next_ovr.async_abort_override = wdata_i[MOW_AMO_BIT];
					next_ovr.irq_mask_override    = wdata_i[MOW_IMO_BIT];
					next_ovr.fiq_mask_override    = wdata_i[MOW_FMO_BIT];
				end
				else
				begin
					next_rdata = MOW_RESET_VALUE;
					next_rdata[MOW_AMO_BIT] = ovr.async_abort_override;
					next_rdata[MOW_IMO_BIT] = ovr.irq_mask_override;
					next_rdata[MOW_FMO_BIT] = ovr.fiq_mask_override;
					next_rvalid = 1'b1;
				end
			end
			else if (sel_i == MOW_SEL_TTB)
			begin
				if (!st_i.privileged)
				begin
					next_undef = 1'b1;
				end
				else if (wr_i && st_i.in_secure && secure_cfg_write_lock_i)
				begin
					next_undef = 1'b1;
				end
				else if (wr_i && st_i.in_secure)
				begin
					next_ttb_s = ttb_write(wdata_i);
				end
				else if (wr_i)
				begin
					next_ttb_ns = ttb_write(wdata_i);
				end
				else
				begin
					next_rdata  = ttb_read(st_i.in_secure ? ttb_s : ttb_ns);
					next_rvalid = 1'b1;
				end
			end
			else
			begin
				// Unknown selector answers undefined rather than silently
				next_undef = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ovr    <= '0;
			ttb_s  <= '0;
			ttb_ns <= '0;
			rdata  <= MOW_RESET_VALUE;
			rvalid <= 1'b0;
			undef  <= 1'b0;
		end
		else
		begin
			ovr    <= next_ovr;
			ttb_s  <= next_ttb_s;
			ttb_ns <= next_ttb_ns;
			rdata  <= next_rdata;
			rvalid <= next_rvalid;
			undef  <= next_undef;
		end
	end

	assign rdata_o  = rdata;
	assign rvalid_o = rvalid;
	assign undef_o  = undef;
	// Walks use the copy of the current security state
	assign ttb_cur  = st_i.in_secure ? ttb_s : ttb_ns;

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	mow_mask_gate u_gate
	(
		.st_i             (st_i),
		.ovr_i            (ovr),
		.abort_mask_i     (abort_mask_i),
		.irq_mask_i       (irq_mask_i),
		.fiq_mask_i       (fiq_mask_i),
		.abort_mask_eff_o (abort_mask_eff_o),
		.irq_mask_eff_o   (irq_mask_eff_o),
		.fiq_mask_eff_o   (fiq_mask_eff_o)
	);

	mow_walk_attr u_walk
	(
		.ttb_i   (ttb_cur),
		.split_i (split_i),
		.walk_o  (walk_o)
	);
endmodule

// File: dv/mow_top_checker.sv
// Checker for mow_top: transfer answers, mask gating, walk view.
// Assumes one core clock; bound to mow_top below.
`timescale 1ns/1ns
module mow_top_checker
(
	// Clock and reset
	input wire logic                            clk_i,
	input wire logic                            reset_n_i,
	// Watched ports
	input wire mow_pkg::mow_state_t             st_i,
	input wire logic                            secure_cfg_write_lock_i,
	input wire logic [mow_pkg::MOW_SPLIT_W-1:0] split_i,
	input wire logic                            req_i,
	input wire logic                            wr_i,
	input wire mow_pkg::mow_sel_t               sel_i,
	input wire logic [31:0]                     wdata_i,
	input wire logic [31:0]                     rdata_o,
	input wire logic                            rvalid_o,
	input wire logic                            undef_o,
	input wire logic                            abort_mask_i,
	input wire logic                            irq_mask_i,
	input wire logic                            fiq_mask_i,
	input wire logic                            abort_mask_eff_o,
	input wire logic                            irq_mask_eff_o,
	input wire logic                            fiq_mask_eff_o,
	input wire mow_pkg::mow_walk_t              walk_o
);
	import mow_pkg::*;
	// ------
	// Properties
	// ------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	logic ttb_ok;
	assign ttb_ok = req_i && wr_i && sel_i == MOW_SEL_TTB && st_i.privileged
		&& !(st_i.in_secure && secure_cfg_write_lock_i);
	AST_OVR_REFUSE: assert property (req_i && sel_i == MOW_SEL_OVR && !(st_i.in_secure && st_i.privileged)
		|=> undef_o && !rvalid_o) else $error("override access not refused");
	AST_TTB_REFUSE: assert property (req_i && sel_i == MOW_SEL_TTB && !st_i.privileged
		|=> undef_o) else $error("user table base access not refused");
	AST_LOCK: assert property (req_i && wr_i && sel_i == MOW_SEL_TTB && st_i.in_secure && st_i.privileged
		&& secure_cfg_write_lock_i |=> undef_o) else $error("locked write not refused");
	AST_WR_SILENT: assert property (ttb_ok |=> !undef_o && !rvalid_o) else $error("legal write answered");
	AST_RD_ANS: assert property (req_i && !wr_i && sel_i == MOW_SEL_TTB && st_i.privileged
		|=> rvalid_o && !undef_o) else $error("read not answered");
	AST_ABORT_IGN: assert property ((st_i.in_secure || !st_i.ext_abort_routing)
		|-> abort_mask_eff_o == abort_mask_i) else $error("abort override not ignored");
	AST_IRQ_IGN: assert property ((st_i.in_secure || !st_i.irq_routing)
		|-> irq_mask_eff_o == irq_mask_i) else $error("irq override not ignored");
	AST_FIQ_IGN: assert property ((st_i.in_secure || !st_i.fiq_routing)
		|-> fiq_mask_eff_o == fiq_mask_i) else $error("fiq override not ignored");
	AST_INNER: assert property (ttb_ok ##1 $stable(st_i) |-> walk_o.dcache_lookup == $past(wdata_i[6]))
		else $error("dcache lookup wrong");
	AST_OUTER: assert property (ttb_ok ##1 $stable(st_i) |-> walk_o.outer_walk_attr == $past(wdata_i[4:3])
		&& walk_o.shared == $past(wdata_i[1])) else $error("outer or share wrong");
	AST_ALIGN: assert property ((walk_o.walk_base & ~(32'hFFFF_FFFF << (MOW_SPLIT_BASE - split_i))) == 32'h0)
		else $error("walk base not aligned");
	AST_RD_TTB: assert property (rvalid_o && $past(sel_i) == MOW_SEL_TTB |-> rdata_o[5] == 1'h0
		&& rdata_o[2] == 1'h0) else $error("table base bits 5 or 2 set");
	AST_RD_OVR: assert property (rvalid_o && $past(sel_i) == MOW_SEL_OVR |-> rdata_o[31:9] == 23'h0
		&& rdata_o[5:0] == 6'h0) else $error("override reserved bits set");
	cover property (rvalid_o);
	cover property (undef_o);
	cover property (ttb_ok);
	cover property (irq_mask_i && !irq_mask_eff_o);
endmodule

bind mow_top mow_top_checker chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .st_i(st_i),
	.secure_cfg_write_lock_i(secure_cfg_write_lock_i), .split_i(split_i), .req_i(req_i), .wr_i(wr_i),
	.sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .undef_o(undef_o),
	.abort_mask_i(abort_mask_i), .irq_mask_i(irq_mask_i), .fiq_mask_i(fiq_mask_i),
	.abort_mask_eff_o(abort_mask_eff_o), .irq_mask_eff_o(irq_mask_eff_o),
	.fiq_mask_eff_o(fiq_mask_eff_o), .walk_o(walk_o));

// File: dv/mow_top_tb.sv
// Self-checking bench for mow_top.
// Assumes one-cycle strobes answered one cycle later.
`timescale 1ns/1ns
module mow_top_tb;
	import mow_pkg::*;
	// ------
	// Signals
	// ------
	logic        clk_i = 1'h0;
	logic        reset_n_i = 1'h0;
	mow_state_t  st_i = 5'h18;
	logic        lock_i = 1'h0;
	logic [2:0]  split_i = 3'h0;
	logic [2:0]  msk_i = 3'h7;
	logic        req_i = 1'h0;
	logic        wr_i = 1'h0;
	mow_sel_t    sel_i = MOW_SEL_NONE;
	logic [31:0] wdata_i = 32'h0;
	logic [31:0] rdata_o;
	logic        rvalid_o, undef_o, ab_o, iq_o, fq_o;
	mow_walk_t   walk_o;
	int          n_errors = 0;
	int          comparisons = 0;
	always #4 clk_i = ~clk_i;
	mow_top dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .st_i(st_i), .secure_cfg_write_lock_i(lock_i),
		.split_i(split_i), .req_i(req_i), .wr_i(wr_i), .sel_i(sel_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
		.rvalid_o(rvalid_o), .undef_o(undef_o),
		.abort_mask_i(msk_i[2]), .irq_mask_i(msk_i[1]), .fiq_mask_i(msk_i[0]),
		.abort_mask_eff_o(ab_o), .irq_mask_eff_o(iq_o), .fiq_mask_eff_o(fq_o), .walk_o(walk_o));
	// ------
	// Tasks
	// ------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xf(input logic w, input mow_sel_t s, input logic [31:0] d);
		@(posedge clk_i);
		req_i <= 1'h1;
		wr_i <= w;
		sel_i <= s;
		wdata_i <= d;
		@(posedge clk_i);
		req_i <= 1'h0;
		#1;
	endtask
	task automatic rd(input mow_sel_t s, input logic [31:0] e);
		xf(1'h0, s, 32'h0);
		chk({rvalid_o, undef_o}, 32'h2);
		chk(rdata_o, e);
	endtask
	task automatic rf(input logic w, input mow_sel_t s);
		xf(w, s, 32'h0);
		chk({rvalid_o, undef_o}, 32'h1);
	endtask
	task automatic go(input mow_state_t s);
		@(posedge clk_i);
		st_i <= s;
		#1;
	endtask
	task automatic t_ovr;
		rd(MOW_SEL_OVR, 32'h0);
		rd(MOW_SEL_TTB, 32'h0);
		xf(1'h1, MOW_SEL_OVR, 32'hFFFF_FFFF);
		rd(MOW_SEL_OVR, 32'h1C0);
		go(5'h08);
		rf(1'h1, MOW_SEL_OVR);
		go(5'h10);
		rf(1'h0, MOW_SEL_OVR);
	endtask
	task automatic t_mask;
		go(5'h0F);
		chk({ab_o, iq_o, fq_o}, 32'h0);
		go(5'h0E);
		chk({ab_o, iq_o, fq_o}, 32'h1);
		go(5'h09);
		chk({ab_o, iq_o, fq_o}, 32'h6);
		go(5'h1F);
		chk({ab_o, iq_o, fq_o}, 32'h7);
		@(posedge clk_i);
		msk_i <= 3'h5;
		#1;
		chk({ab_o, iq_o, fq_o}, 32'h5);
		go(5'h18);
		xf(1'h1, MOW_SEL_OVR, 32'hFFFF_FE3F);
		rd(MOW_SEL_OVR, 32'h0);
		go(5'h0F);
		chk({ab_o, iq_o, fq_o}, 32'h5);
	endtask
	task automatic t_ttb;
		go(5'h18);
		xf(1'h1, MOW_SEL_TTB, 32'hFFFF_FFFF);
		rd(MOW_SEL_TTB, 32'hFFFF_FFDB);
		for (int n = 0; n < 8; n++)
		begin
			@(posedge clk_i);
			split_i <= 3'(n);
			#1;
			chk(walk_o.walk_base, 32'hFFFF_FFFF << (14 - n));
		end
	endtask
	task automatic t_bank;
		logic [31:0] d;
		go(5'h08);
		rd(MOW_SEL_TTB, 32'h0);
		for (int k = 0; k < 4; k++)
		begin
			d = 32'h0000_4024 | (k[0] << 6) | (k << 3) | (k[0] << 1) | k[1];
			xf(1'h1, MOW_SEL_TTB, d);
			chk({walk_o.dcache_lookup, walk_o.outer_walk_attr, walk_o.shared}, {k[0], k[1:0], k[0]});
			rd(MOW_SEL_TTB, d & 32'hFFFF_FFDB);
		end
		go(5'h18);
		rd(MOW_SEL_TTB, 32'hFFFF_FFDB);
		go(5'h10);
		rf(1'h0, MOW_SEL_TTB);
		rf(1'h1, MOW_SEL_TTB);
	endtask
	task automatic t_lock;
		go(5'h18);
		@(posedge clk_i);
		lock_i <= 1'h1;
		rf(1'h1, MOW_SEL_TTB);
		rd(MOW_SEL_TTB, 32'hFFFF_FFDB);
		go(5'h08);
		xf(1'h1, MOW_SEL_TTB, 32'h0000_8000);
		rd(MOW_SEL_TTB, 32'h0000_8000);
		@(posedge clk_i);
		lock_i <= 1'h0;
		rf(1'h0, MOW_SEL_NONE);
	endtask
	task automatic t_reset;
		@(posedge clk_i);
		reset_n_i <= 1'h0;
		@(posedge clk_i);
		reset_n_i <= 1'h1;
		go(5'h18);
		rd(MOW_SEL_OVR, 32'h0);
		rd(MOW_SEL_TTB, 32'h0);
		chk(walk_o.walk_base, 32'h0);
	endtask
	task automatic print_verdict;
		$display("Errors: %0d, comparisons: %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'h1;
		t_ovr();
		t_mask();
		t_ttb();
		t_bank();
		t_lock();
		t_reset();
		print_verdict();
	end
	// Whole run needs about 90 cycles
	initial
	begin
		repeat (3000) @(posedge clk_i);
		n_errors++;
		print_verdict();
	end
endmodule
